// ==== hw/fdc_status_params.svh ====
`ifndef FDC_STATUS_PARAMS_SVH
`define FDC_STATUS_PARAMS_SVH
`define OFS_MAIN_STATUS 8'h04
`define OFS_RATE_SELECT 8'h04
`define OFS_DATA 8'h05
`define MAIN_STATUS_RESET 8'h00
`define RATE_SELECT_RESET 8'h00
`define BIT_READY 7
`define BIT_DIRECTION 6
`define BIT_NON_DMA 5
`define BIT_CMD_BUSY 4
`define BIT_SOFT_RESET 7
`define BIT_LOW_POWER 6
`define BIT_RESERVED 5
`define PRECOMP_MSB 4
`define PRECOMP_LSB 2
`define RATE_MSB 1
`define RATE_LSB 0
`define PRECOMP_STEP_PS 41700
`define PRECOMP_DEFAULT_LOW_PS 125000
`define PRECOMP_DEFAULT_FAST_PS 41700
`define SOFT_RESET_CYCLES 2
`endif

// ==== hw/fdc_status_pkg.sv ====
package fdc_status_pkg;
   typedef enum logic [1:0] {rate_500k, rate_300k, rate_250k, rate_1m} rate_code_t;
   typedef struct packed
   {
      logic ready;
      logic direction;
      logic non_dma;
      logic cmd_busy;
      logic [3:0] drive_busy;
   } main_status_t;
   typedef struct packed
   {
      logic low_power;
      logic [2:0] precomp_code;
      rate_code_t rate;
   } rate_cfg_t;
   typedef struct packed
   {
      logic [17:0] precomp_ps;
      logic [10:0] rate_kbps;
      logic rate_illegal;
   } link_timing_t;
endpackage

// ==== hw/fdc_rate_decode.sv ====
`timescale 1ns/100ps
`include "fdc_status_params.svh"
module fdc_rate_decode
   import fdc_status_pkg::*;
(
   input wire clk_sys,
   input wire rst_n,
   input rate_cfg_t cfg,
   input wire fm_mode,
   output link_timing_t timing
);
   typedef struct packed
   {
      link_timing_t timing;
   } state_t;
   state_t state;
   state_t next_state;

   always_comb
   begin
      next_state = state;
      case (cfg.rate)
         rate_500k: next_state.timing.rate_kbps = fm_mode ? 11'd250 : 11'd500;
         rate_300k: next_state.timing.rate_kbps = fm_mode ? 11'd150 : 11'd300;
         rate_250k: next_state.timing.rate_kbps = fm_mode ? 11'd125 : 11'd250;
         rate_1m: next_state.timing.rate_kbps = fm_mode ? 11'd0 : 11'd1000;
         default: next_state.timing.rate_kbps = 11'd500;
      endcase
      next_state.timing.rate_illegal = fm_mode && (cfg.rate == rate_1m);
      case (cfg.precomp_code)
         3'b000:
         begin
            // default delay depends on rate
            if (cfg.rate == rate_1m)
               next_state.timing.precomp_ps = 18'(`PRECOMP_DEFAULT_FAST_PS);
            else
               next_state.timing.precomp_ps = 18'(`PRECOMP_DEFAULT_LOW_PS);
         end
         3'b001: next_state.timing.precomp_ps = 18'd41700;
         3'b010: next_state.timing.precomp_ps = 18'd83300;
         3'b011: next_state.timing.precomp_ps = 18'd125000;
         3'b100: next_state.timing.precomp_ps = 18'd166700;
         3'b101: next_state.timing.precomp_ps = 18'd208300;
         3'b110: next_state.timing.precomp_ps = 18'd250000;
         3'b111: next_state.timing.precomp_ps = 18'd0;
         default: next_state.timing.precomp_ps = 18'd0;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         state <= '0;
      else
         state <= next_state;
   end

   assign timing = state.timing;
endmodule

// ==== hw/floppy_status_rate_select.sv ====
`timescale 1ns/100ps
`include "fdc_status_params.svh"
module floppy_status_rate_select
   import fdc_status_pkg::*;
(
   input wire clk_sys,
   input wire rst_n,
   input wire [7:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [7:0] avs_writedata,
   output logic [7:0] avs_readdata,
   output logic avs_waitrequest,
   input wire core_ready,
   input wire core_to_host,
   input wire core_non_dma,
   input wire core_cmd_busy,
   input wire [3:0] core_drive_seek,
   input wire fm_mode,
   output logic soft_reset,
   output logic low_power,
   output logic [2:0] precomp_code,
   output logic [1:0] rate_code,
   output logic [17:0] precomp_ps,
   output logic [10:0] rate_kbps,
   output logic rate_illegal
);
   typedef struct packed
   {
      logic ack;
      logic [7:0] rdata;
      main_status_t status;
      rate_cfg_t cfg;
      logic soft_reset;
      logic [1:0] reset_count;
   } state_t;
   state_t state;
   state_t next_state;
   link_timing_t timing;

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
      hit = (addr == ofs);
   endfunction

   always_comb
   begin
      logic req;
      logic take;
      logic status_rd;
      logic rate_wr;
      logic data_acc;
      req = 1'b0;
      take = 1'b0;
      status_rd = 1'b0;
      rate_wr = 1'b0;
      data_acc = 1'b0;
      next_state = state;
      req = (avs_read || avs_write) && !state.ack;
      // side effects land on the answer edge, when the master sees waitrequest low
      take = (avs_read || avs_write) && state.ack;
      status_rd = take && avs_read && hit(avs_address, `OFS_MAIN_STATUS);
      rate_wr = take && avs_write && hit(avs_address, `OFS_RATE_SELECT);
      data_acc = take && hit(avs_address, `OFS_DATA);
      // one wait state per access, then the answer edge
      next_state.ack = req;
      if (req)
      begin
         next_state.rdata = 8'h00;
         if (avs_read && hit(avs_address, `OFS_MAIN_STATUS))
            next_state.rdata = state.status;
      end
      // status tracks the core live, but is forced clear through a soft reset
      if (state.soft_reset)
         next_state.status = `MAIN_STATUS_RESET;
      else
      begin
         next_state.status.ready = core_ready;
         next_state.status.direction = core_to_host;
         next_state.status.non_dma = core_non_dma;
         next_state.status.cmd_busy = core_cmd_busy;
         next_state.status.drive_busy = core_drive_seek;
      end
      if (state.reset_count != 2'd0)
         next_state.reset_count = state.reset_count - 2'd1;
      next_state.soft_reset = (state.reset_count > 2'd1);
      if (rate_wr)
      begin
         next_state.cfg.precomp_code = avs_writedata[`PRECOMP_MSB:`PRECOMP_LSB];
         next_state.cfg.rate = rate_code_t'(avs_writedata[`RATE_MSB:`RATE_LSB]);
         // reserved bit 5 is ignored, software keeps it at zero
         if (avs_writedata[`BIT_LOW_POWER])
            next_state.cfg.low_power = 1'b1;
         if (avs_writedata[`BIT_SOFT_RESET])
         begin
            next_state.soft_reset = 1'b1;
            next_state.reset_count = 2'(`SOFT_RESET_CYCLES);
            next_state.cfg.low_power = 1'b0;
         end
      end
      if (status_rd || data_acc)
         next_state.cfg.low_power = 1'b0;
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= '0;
      end
      else
         state <= next_state;
   end

   fdc_rate_decode u_decode
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .cfg(state.cfg),
      .fm_mode(fm_mode),
      .timing(timing)
   );

   assign avs_readdata = state.rdata;
   assign avs_waitrequest = (avs_read || avs_write) && !state.ack;
   assign soft_reset = state.soft_reset;
   assign low_power = state.cfg.low_power;
   assign precomp_code = state.cfg.precomp_code;
   assign rate_code = state.cfg.rate;
   assign precomp_ps = timing.precomp_ps;
   assign rate_kbps = timing.rate_kbps;
   assign rate_illegal = timing.rate_illegal;
endmodule

// ==== test/floppy_status_sva.sv ====
`timescale 1ns/100ps
module floppy_status_sva (
   input wire clk_sys, input wire rst_n, input wire [7:0] avs_address, input wire avs_read,
   input wire avs_write, input wire [7:0] avs_writedata, input logic avs_waitrequest, input wire fm_mode,
   input logic soft_reset, input logic low_power, input logic [2:0] precomp_code, input logic [1:0] rate_code,
   input logic [17:0] precomp_ps, input logic [10:0] rate_kbps, input logic rate_illegal
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   wire acc = (avs_read | avs_write) & !avs_waitrequest;
   wire wr4 = acc & avs_write & (avs_address == 8'h04);
   wire [4:0] wr_cfg = avs_writedata[4:0];
   sequence s_req; wr4 & avs_writedata[7]; endsequence
   sequence s_pulse; soft_reset [*2] ##1 !soft_reset; endsequence
   property p_wait; $rose(avs_read | avs_write) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
   a_wait: assert property (p_wait) else $error("wait state count wrong");
   property p_srst; s_req |=> s_pulse; endproperty
   a_srst: assert property (p_srst) else $error("soft reset pulse wrong");
   property p_cfg; wr4 |=> {precomp_code, rate_code} == $past(wr_cfg); endproperty
   a_cfg: assert property (p_cfg) else $error("config not taken");
   property p_keep; soft_reset |=> $stable(precomp_code) && $stable(rate_code); endproperty
   a_keep: assert property (p_keep) else $error("config lost on soft reset");
   property p_lpon; wr4 & (avs_writedata[7:6] == 2'b01) |=> low_power; endproperty
   a_lpon: assert property (p_lpon) else $error("low power not entered");
   property p_lpoff; acc & (avs_address == 8'h05 | avs_address == 8'h04 & avs_read) |=> !low_power; endproperty
   a_lpoff: assert property (p_lpoff) else $error("low power not left");
   property p_fast;
      !fm_mode & $stable(fm_mode) & rate_code == 2'h3 & $stable(rate_code) & precomp_code == 3'h0
         & $stable(precomp_code) |=> rate_kbps == 11'd1000 & precomp_ps == 18'd41700 & !rate_illegal;
   endproperty
   a_fast: assert property (p_fast) else $error("fast rate decode wrong");
   property p_ill; fm_mode & $stable(fm_mode) & rate_code == 2'h3 & $stable(rate_code) |=> rate_illegal; endproperty
   a_ill: assert property (p_ill) else $error("illegal code not flagged");
endmodule
bind floppy_status_rate_select floppy_status_sva floppy_status_sva_inst (.*);

// ==== test/avalon_host_model.sv ====
`timescale 1ns/100ps
module avalon_host_model (
   input wire clk_sys,
   input logic avs_waitrequest,
   input logic [7:0] avs_readdata,
   output logic [7:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [7:0] avs_writedata
);
   initial {avs_address, avs_read, avs_write, avs_writedata} = 18'h0;
   // one byte access, held until waitrequest is seen low
   task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      logic busy;
      busy = 1'b1;
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d & 8'hdf; // reserved bit kept low
      avs_read <= !wr;
      avs_write <= wr;
      // sample away from the edge so the answer edge is not raced
      do
      begin
         @(negedge clk_sys);
         busy = avs_waitrequest;
         q = avs_readdata;
         @(posedge clk_sys);
      end
      while (busy !== 1'b0);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // released lines flip so stale values never look valid
      avs_address <= ~a;
      avs_writedata <= ~d;
   endtask
endmodule

// ==== test/tb_floppy_status_rate_select.sv ====
`timescale 1ns/100ps
module tb_floppy_status_rate_select;
   logic clk_sys = 1'b0, rst_n = 1'b0, fm_mode = 1'b0, core_ready = 1'b0, core_to_host = 1'b0;
   logic core_non_dma = 1'b0, core_cmd_busy = 1'b0, avs_read, avs_write, avs_waitrequest;
   logic soft_reset, low_power, rate_illegal;
   logic [3:0] core_drive_seek = 4'h0;
   logic [7:0] avs_address, avs_writedata, avs_readdata, q;
   logic [2:0] precomp_code;
   logic [1:0] rate_code;
   logic [17:0] precomp_ps;
   logic [10:0] rate_kbps;
   int mismatches = 0, compares = 0;
   int kbps[4] = '{500, 300, 250, 1000};
   int ps[8] = '{0, 41700, 83300, 125000, 166700, 208300, 250000, 0};
   initial forever #20 clk_sys = ~clk_sys;
   floppy_status_rate_select floppy_status_rate_select_inst (.*);
   avalon_host_model avalon_host_model_inst (.*);
   task automatic chk(input logic [17:0] g, input logic [17:0] e);
      compares++;
      if (g !== e)
      begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic finish_test();
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      avalon_host_model_inst.access(1'b0, a, 8'h00, q);
      chk(q, e);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      avalon_host_model_inst.access(1'b1, a, d, q);
   endtask
   task automatic settle();
      repeat (3) @(posedge clk_sys);
      #1;
   endtask
   initial
   begin
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      rdchk(8'h04, 8'h00);
      for (int i = 0; i < 8; i++)
      begin
         @(posedge clk_sys);
         {core_ready, core_to_host, core_non_dma, core_cmd_busy, core_drive_seek} <= 8'h01 << i;
         repeat (4) @(posedge clk_sys);
         rdchk(8'h04, 8'h01 << i);
      end
      wr(8'h04, 8'h1f);
      rdchk(8'h04, 8'h80);
      for (int f = 0; f < 2; f++) for (int c = 0; c < 8; c++) for (int r = 0; r < 4; r++)
      begin
         @(posedge clk_sys);
         fm_mode <= f[0];
         wr(8'h04, {3'h0, c[2:0], r[1:0]});
         settle();
         chk(rate_code, r[1:0]);
         chk(precomp_code, c[2:0]);
         chk(rate_kbps, 18'(f == 0 ? kbps[r] : (r == 3 ? 0 : kbps[r] / 2)));
         chk(rate_illegal, f == 1 && r == 3);
         if (!(f == 1 && r == 3)) chk(precomp_ps, 18'(c == 0 ? (r == 3 ? 41700 : 125000) : ps[c]));
      end
      @(posedge clk_sys);
      fm_mode <= 1'b0;
      wr(8'h04, 8'h43);
      settle();
      chk(low_power, 1'b1);
      rdchk(8'h04, 8'h80);
      settle();
      chk(low_power, 1'b0);
      rdchk(8'h04, 8'h80);
      wr(8'h04, 8'h43);
      rdchk(8'h05, 8'h00);
      settle();
      chk(low_power, 1'b0);
      wr(8'h04, 8'h43);
      wr(8'h04, 8'hc3);
      #1;
      chk(soft_reset, 1'b1);
      rdchk(8'h04, 8'h00);
      settle();
      chk(soft_reset, 1'b0);
      chk(low_power, 1'b0);
      chk(precomp_ps, 18'd41700);
      wr(8'h07, 8'h00);
      rdchk(8'h07, 8'h00);
      finish_test();
   end
   initial
   begin
      #400000;
      mismatches++;
      finish_test();
   end
endmodule
